// [verilog/asr_pkg.sv]
/*
 * constants, register map and state record of the
 * asynchronous serial receiver.
 * assumes a single 100 MHz clock and a classic wishbone register bus.
 */
// How it works
// R1 - zero at stop position sets framing error
// R2 - break character also sets framing error
// R3 - framing error rises with receive full
// R4 - one stray stop sample noise, more framing
// R5 - valid falling edge realigns rt phase
// R6 - sixteen rt per bit, stop RT8-RT10
// R7 - nine-bit stop sampled after ten bits
// R8 - standby bit suppresses receiver interrupts
// R9 - address mark wakes and sets receive full
// R10 - software re-enters standby on foreign address
// R11 - waking idle sets no idle, no full
// R12 - select counts ones after start or stop
// R13 - immediate wake on idle line allowed
// R14 - receive full interrupt gated by enable
// R15 - idle after 10 or 11 ones, gated
// R16 - overrun keeps old data, drops new
// R17 - noise flag on any bit, gated
// R18 - framing error interrupt gated by enable
// R19 - parity mismatch flag, gated error interrupt
// R20 - receiver keeps running in wait mode
// R21 - stop mode halts, keeps all registers
// R22 - break clear enable lets flags clear
// R23 - without it flags cannot clear during break
// R24 - stop majority vote, disagreement means noise
// R25 - break clears data and ninth bit
// R26 - rt clock is sixteen times baud
// R27 - error interrupt ors enabled error flags

package asr_pkg;

    // ********************************************************
    // register map
    // ********************************************************
    localparam logic [7:0]  ADR_WORD_MASK  = 8'hfc;
    localparam logic [7:0]  ADR_STATUS_ONE = 8'h00;
    localparam logic [7:0]  ADR_DATA       = 8'h04;
    localparam logic [7:0]  ADR_CTRL_ONE   = 8'h08;
    localparam logic [7:0]  ADR_BAUD       = 8'h0c;
    localparam logic [15:0] CTRL_WMASK     = 16'h3f7f;
    localparam logic [15:0] BAUD_RST       = 16'h0035;

    // ********************************************************
    // timing in rt cycles
    // ********************************************************
    localparam int          RT_PER_BIT = 16;
    localparam logic [4:0]  RT_FIRST   = 5'h01;
    localparam logic [4:0]  RT_S1      = 5'h08;
    localparam logic [4:0]  RT_S2      = 5'h09;
    localparam logic [4:0]  RT_S3      = 5'h0a;
    localparam logic [4:0]  RT_LAST    = 5'(RT_PER_BIT);
    localparam logic [3:0]  BITS8      = 4'h8;
    localparam logic [3:0]  BITS9      = 4'h9;
    localparam logic [7:0]  QUIET8     = 8'(10 * RT_PER_BIT);
    localparam logic [7:0]  QUIET9     = 8'(11 * RT_PER_BIT);

    typedef enum logic [1:0] {
        ASR_IDLE  = 2'b00,
        ASR_START = 2'b01,
        ASR_DATA  = 2'b11,
        ASR_STOP  = 2'b10
    } asr_rx_e;

    // control_register_one, bit 0 is rx_en
    typedef struct packed {
        logic [1:0] rsv_hi;
        logic       parity_irq_enable;
        logic       framing_irq_enable;
        logic       noise_irq_enable;
        logic       overrun_irq_enable;
        logic       line_quiet_irq_enable;
        logic       receive_full_irq_enable;
        logic       rsv7;
        logic       receiver_standby;
        logic       parity_odd;
        logic       parity_en;
        logic       quiet_count_start_select;
        logic       wake_addr;
        logic       nine_bit;
        logic       rx_en;
    } asr_ctrl_s;

    // status_register_one, bit 0 is receive full
    typedef struct packed {
        logic break_seen;
        logic parity_error_flag;
        logic framing_error_flag;
        logic noise_flag;
        logic overrun_flag;
        logic line_quiet_flag;
        logic receive_full_flag;
    } asr_stat_s;

    typedef struct packed {
        asr_rx_e    st;
        logic [4:0] rt;
        logic [3:0] bit_ix;
        logic [2:0] smp;
        logic       prev;
        logic [8:0] shf;
        logic       noisy;
        logic [7:0] quiet;
        logic       quiet_seen;
        asr_ctrl_s  ctl;
        logic [15:0] baud;
        asr_stat_s  stat;
        logic [7:0] data;
        logic       bit8;
        logic       armed;
        logic       ack;
        logic [31:0] rdat;
    } asr_state_s;

    localparam asr_state_s ASR_STATE_RST = '{
        st: ASR_IDLE, prev: 1'b1, quiet_seen: 1'b1,
        baud: BAUD_RST, default: '0};

    typedef struct packed {
        logic ff1;
        logic ff2;
        logic ff3;
        logic q;
    } asr_sync_s;

    typedef struct packed {
        logic [15:0] cnt;
        logic        tick;
    } asr_div_s;

endpackage : asr_pkg

// [verilog/asr_sync3.sv]
/*
 * three-stage synchroniser for the receive pin.
 * assumes an asynchronous input that idles high.
 */
`timescale 1ns/1ps
`default_nettype none

module asr_sync3
    import asr_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic d_i,
    output logic      q_o
);

    asr_sync_s s;
    asr_sync_s next_s;

    // output follows only once stages two and three agree
    always_comb begin
        next_s     = s;
        next_s.ff1 = d_i;
        next_s.ff2 = s.ff1;
        next_s.ff3 = s.ff2;
        if (s.ff2 == s.ff3) begin
            next_s.q = s.ff3;
        end
    end

    // reset to the idle level so no false edge appears
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '1;
        end else begin
            s <= next_s;
        end
    end

    assign q_o = s.q;

endmodule : asr_sync3

`default_nettype wire

// [verilog/asr_tick_div.sv]
/*
 * rt sample clock divider: one-cycle enable every div_i+1 cycles.
 * assumes en_i low while the receiver must stand still.
 */
`timescale 1ns/1ps
`default_nettype none

module asr_tick_div
    import asr_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        en_i,
    input  wire logic [15:0] div_i,
    output logic             tick_o
);

    asr_div_s s;
    asr_div_s next_s;

    // count up to the divisor, then pulse and restart
    always_comb begin
        next_s      = s;
        next_s.tick = 1'b0;
        if (!en_i) begin
            next_s.cnt = '0;
        end else if (s.cnt >= div_i) begin
            next_s.cnt  = '0;
            next_s.tick = 1'b1; // see R26
        end else begin
            next_s.cnt = s.cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick_o = s.tick;

endmodule : asr_tick_div

`default_nettype wire

// [verilog/asr_receiver.sv]
/*
 * asynchronous serial receiver with error flags, standby wakeup,
 * interrupt requests and debug-break flag protection.
 * assumes a classic wishbone master, a raw receive pin and the
 * system unit driving the break levels.
 */
// Local design decisions: the address map and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none

module asr_receiver
    import asr_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        rxd_i,
    input  wire logic        stop_mode_i,
    input  wire logic        dbg_break_i,
    input  wire logic        break_clear_enable_i,
    output logic             rx_irq_o,
    output logic             err_irq_o
);

    // ********************************************************
    // declarations
    // ********************************************************
    asr_state_s  s;
    asr_state_s  next_s;
    logic        rxd;
    logic        rt_tick;
    logic        req;
    logic        can_clr;
    logic [7:0]  adr;
    logic [15:0] wm;
    logic [3:0]  nbits;
    logic [7:0]  qthr;
    logic [2:0]  vote;
    logic        maj;
    logic        dis;
    logic [8:0]  d9;
    logic        msb;
    logic        par_bad;
    logic        fall;
    logic [4:0]  cur;
    logic [3:0]  bix;
    logic        fe;
    logic        brk;
    logic        wake;

    // ********************************************************
    // pin synchroniser and rt divider
    // ********************************************************
    asr_sync3 u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (rxd_i),
        .q_o   (rxd)
    );

    // stop mode freezes the rt clock; registers stay as they are
    asr_tick_div u_div (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .en_i   (s.ctl.rx_en & ~stop_mode_i), // see R21
        .div_i  (s.baud),
        .tick_o (rt_tick)
    );

    // byte lanes to a 16-bit write mask
    function automatic logic [15:0] lanes(input logic [3:0] sel);
        lanes = {{8{sel[1]}}, {8{sel[0]}}};
    endfunction : lanes

    // ********************************************************
    // next-state logic
    // ********************************************************
    always_comb begin
        next_s  = s;
        fall    = 1'b0;
        cur     = s.rt;
        bix     = s.bit_ix;
        fe      = 1'b0;
        brk     = 1'b0;
        wake    = 1'b0;
        adr     = wb_adr_i & ADR_WORD_MASK;
        wm      = lanes(wb_sel_i);
        req     = wb_cyc_i & wb_stb_i & ~s.ack;
        next_s.ack = req;
        // a break with protection on must not clear any flag
        can_clr = ~dbg_break_i | break_clear_enable_i; // see R22 R23

        // register reads, answered one cycle after the strobe
        if (req && !wb_we_i) begin
            if (adr == ADR_STATUS_ONE) begin
                next_s.rdat = 32'({s.st != ASR_IDLE, s.stat});
            end else if (adr == ADR_DATA) begin
                next_s.rdat = 32'({s.bit8, s.data});
            end else if (adr == ADR_CTRL_ONE) begin
                next_s.rdat = 32'(s.ctl);
            end else if (adr == ADR_BAUD) begin
                next_s.rdat = 32'(s.baud);
            end else begin
                next_s.rdat = '0;
            end
        end

        // two-step clear: status read arms, data read clears
        if (req && !wb_we_i && can_clr) begin // see R22 R23
            if (adr == ADR_STATUS_ONE) begin
                next_s.armed = 1'b1;
            end else if (adr == ADR_DATA && s.armed) begin
                next_s.stat  = '0;
                next_s.armed = 1'b0;
            end
        end

        // per-character decode helpers
        nbits = s.ctl.nine_bit ? BITS9 : BITS8;
        qthr  = s.ctl.nine_bit ? QUIET9 : QUIET8;
        vote  = {s.smp[1:0], rxd};
        maj   = (vote[0] & vote[1]) | (vote[0] & vote[2])
              | (vote[1] & vote[2]);
        dis   = (vote != '0) && (vote != '1); // see R4 R24
        d9    = s.ctl.nine_bit ? s.shf : {1'b0, s.shf[8:1]};
        msb   = s.ctl.nine_bit ? d9[8] : d9[7];
        // even parity wants zero total, odd wants one
        par_bad = s.ctl.parity_en
                & ((s.ctl.nine_bit ? ^d9 : ^d9[7:0])
                   ^ s.ctl.parity_odd); // see R19

        // ****************************************************
        // receiver, one step per rt tick
        // ****************************************************
        if (!s.ctl.rx_en) begin
            next_s.st = ASR_IDLE;
        end else if (rt_tick) begin
            next_s.prev = rxd;
            fall = s.prev & ~rxd;
            if (s.st == ASR_IDLE) begin
                // the tick that sees the edge counts as RT1
                if (fall) begin
                    next_s.st     = ASR_START;
                    next_s.rt     = RT_FIRST;
                    next_s.bit_ix = '0;
                    next_s.noisy  = 1'b0;
                end
            end else begin
                if (s.rt == RT_LAST) begin
                    cur = RT_FIRST;
                    bix = s.bit_ix + 4'h1; // see R6 R7
                end else begin
                    cur = s.rt + 5'h01;
                end
                // edges inside the sample window are left alone,
                // the vote already treats them as noise
                if (fall && s.st != ASR_START) begin // see R5
                    if (cur > RT_S3) begin
                        cur = RT_FIRST;
                        bix = s.bit_ix + 4'h1;
                    end else if (cur < RT_S1) begin
                        cur = RT_FIRST;
                    end
                end
                next_s.rt     = cur;
                next_s.bit_ix = bix;
                if (cur == RT_S1 || cur == RT_S2) begin
                    next_s.smp = {s.smp[1:0], rxd};
                end else if (cur == RT_S3) begin
                    case (s.st)
                        ASR_START: begin
                            // any one here is noise, bit still a start
                            next_s.noisy = (vote != '0); // see R17
                            next_s.st    = ASR_DATA;
                        end
                        ASR_DATA: begin
                            next_s.shf   = {maj, s.shf[8:1]};
                            next_s.noisy = s.noisy | dis; // see R17
                            if (bix == nbits) begin // see R6 R7
                                next_s.st = ASR_STOP;
                            end
                        end
                        default: begin
                            next_s.st = ASR_IDLE;
                            fe   = ~maj; // see R1 R24
                            // all-zero data with no stop is a break
                            brk  = fe & (d9 == '0); // see R2 R25
                            wake = s.ctl.receiver_standby
                                 & s.ctl.wake_addr & msb; // see R9
                            if (wake) begin
                                next_s.ctl.receiver_standby = 1'b0;
                            end
                            // standby drops characters without flags
                            if (!s.ctl.receiver_standby || wake) begin
                                if (next_s.stat.receive_full_flag) begin
                                    // old character stays put
                                    next_s.stat.overrun_flag = 1'b1; // see R16
                                end else begin
                                    // a break leaves data and bit8 zero
                                    next_s.data = d9[7:0]; // see R25
                                    next_s.bit8 = msb;
                                    next_s.stat.receive_full_flag = 1'b1;
                                    // same edge as receive full
                                    next_s.stat.framing_error_flag =
                                        fe; // see R1 R2 R3
                                    next_s.stat.noise_flag =
                                        s.noisy | dis; // see R4 R17
                                    next_s.stat.parity_error_flag =
                                        par_bad; // see R19
                                    next_s.stat.break_seen = brk;
                                end
                            end
                        end
                    endcase
                end
            end

            // ************************************************
            // idle line detection
            // ************************************************
            // with the stop-bit select set, ones inside a
            // character are not counted
            if (!rxd || (s.ctl.quiet_count_start_select
                         && s.st != ASR_IDLE)) begin // see R12
                next_s.quiet = '0;
                if (!rxd) begin
                    next_s.quiet_seen = 1'b0;
                end
            end else if (s.quiet < qthr) begin
                next_s.quiet = s.quiet + 8'h01;
            end else if (s.ctl.receiver_standby
                         && !s.ctl.wake_addr) begin
                // waking idle raises no flag; a line already idle
                // wakes at once
                next_s.ctl.receiver_standby = 1'b0; // see R11 R13
                next_s.quiet_seen = 1'b1;
            end else if (!s.quiet_seen) begin
                next_s.stat.line_quiet_flag = 1'b1; // see R15
                next_s.quiet_seen = 1'b1;
            end
        end

        // control writes last, so software setting standby wins
        // over a wake in the same cycle
        if (req && wb_we_i) begin
            if (adr == ADR_CTRL_ONE) begin
                wm = wm & CTRL_WMASK;
                next_s.ctl = asr_ctrl_s'((16'(next_s.ctl) & ~wm)
                           | (wb_dat_i[15:0] & wm)); // see R8
            end else if (adr == ADR_BAUD) begin
                next_s.baud = (s.baud & ~wm) | (wb_dat_i[15:0] & wm);
            end
        end
    end

    // ********************************************************
    // state register
    // ********************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= ASR_STATE_RST;
        end else begin
            s <= next_s;
        end
    end

    // ********************************************************
    // outputs
    // ********************************************************
    assign wb_ack_o = s.ack;
    assign wb_dat_o = s.rdat;

    // standby mutes receiver requests; they stay live in wait
    // mode so they can wake the processor
    assign rx_irq_o = ~s.ctl.receiver_standby
        & ((s.stat.receive_full_flag
            & s.ctl.receive_full_irq_enable)   // see R14 R20
         | (s.stat.line_quiet_flag
            & s.ctl.line_quiet_irq_enable));   // see R8 R15

    // each error flag through its own enable
    assign err_irq_o =
          (s.stat.overrun_flag & s.ctl.overrun_irq_enable)
        | (s.stat.noise_flag & s.ctl.noise_irq_enable)     // see R17
        | (s.stat.framing_error_flag
           & s.ctl.framing_irq_enable)                     // see R18
        | (s.stat.parity_error_flag
           & s.ctl.parity_irq_enable);                     // see R19 R27

endmodule : asr_receiver

`default_nettype wire

// [verification/asr_receiver_monitor.sv]
/* port checker for the serial receiver.
   assumes binding into asr_receiver, one clock. */
`timescale 1ns/1ps
`default_nettype none
module asr_receiver_monitor
    import asr_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        stop_mode_i,
    input wire logic        rx_irq_o,
    input wire logic        err_irq_o
);
    // ********************************************
    // bus answers and flag relations
    // ********************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // read answer at a word address
    sequence rd_at(logic [7:0] a);
        wb_ack_o && !wb_we_i && ((wb_adr_i & ADR_WORD_MASK) == a);
    endsequence
    // stop mode held, no bus answer
    sequence frozen;
        stop_mode_i [*3] ##0 !wb_ack_o;
    endsequence
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    AST_ACK_RESP: assert property
        (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("late ack");
    AST_DAT_HOLD: assert property (!wb_ack_o |-> $stable(wb_dat_o))
        else $error("read data moved");
    AST_UNMAPPED: assert property (rd_at(8'h10) |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    AST_CTRL_RSV: assert property (rd_at(ADR_CTRL_ONE) |->
        (wb_dat_o & ~{16'h0, CTRL_WMASK}) == 32'h0)
        else $error("reserved bits set");
    AST_FE_RF: assert property (rd_at(ADR_STATUS_ONE) && wb_dat_o[4]
        |-> wb_dat_o[0])
        else $error("framing flag without receive full");
    AST_BRK_FE: assert property (rd_at(ADR_STATUS_ONE) && wb_dat_o[6]
        |-> wb_dat_o[4] && wb_dat_o[31:8] == 24'h0)
        else $error("break without framing flag");
    AST_RX_GATE: assert property (rd_at(ADR_CTRL_ONE) &&
        wb_dat_o[9:8] == 2'b00 |-> !rx_irq_o)
        else $error("rx irq not gated");
    AST_ERR_GATE: assert property (rd_at(ADR_CTRL_ONE) &&
        wb_dat_o[13:10] == 4'h0 |-> !err_irq_o)
        else $error("err irq not gated");
    AST_STOP_HOLD: assert property (frozen |->
        $stable(rx_irq_o) && $stable(err_irq_o))
        else $error("irq moved in stop mode");
endmodule : asr_receiver_monitor
`default_nettype wire

// [verification/asr_serial_tx.sv]
/* remote transmitter model driving the receive line.
   assumes the bench clock; one bit lasts BIT_CLKS clock cycles. */
`timescale 1ns/1ps
`default_nettype none
module asr_serial_tx #(
    parameter int BIT_CLKS = 16
) (
    input  wire logic clk_i,
    output logic      rxd_o
);
    // line idles high, no clock runs outside frames
    initial rxd_o = 1'b1;
    // start, n data bits lsb first, stop level as asked
    task automatic send(input logic [8:0] d, input int n,
                        input logic stp);
        @(posedge clk_i);
        rxd_o <= 1'b0;
        repeat (BIT_CLKS) @(posedge clk_i);
        for (int i = 0; i < n; i++) begin
            rxd_o <= d[i];
            repeat (BIT_CLKS) @(posedge clk_i);
        end
        rxd_o <= stp; // low stop makes a framing fault
        repeat (BIT_CLKS) @(posedge clk_i);
        rxd_o <= 1'b1;
    endtask : send
endmodule : asr_serial_tx
`default_nettype wire

// [verification/asr_receiver_test.sv]
/* self-checking bench for the serial receiver.
   assumes baud 0 so one rt tick per clock, 16 clocks a bit. */
`timescale 1ns/1ps
`default_nettype none
module asr_receiver_test
    import asr_pkg::*;
;
    logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
    logic [7:0]  adr = '0;
    logic [31:0] dat = '0;
    logic        stop_m = 0, dbg = 0, bce = 0;
    wire  [31:0] dat_o;
    wire         ack, rxd, rx_irq, err_irq;
    int          failures = 0, check_count = 0;
    // ********************************************
    // clock, partner and design
    // ********************************************
    always #5 clk_i = ~clk_i;
    asr_serial_tx tx (.clk_i(clk_i), .rxd_o(rxd));
    asr_receiver DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .rxd_i(rxd), .stop_mode_i(stop_m),
        .dbg_break_i(dbg), .break_clear_enable_i(bce),
        .rx_irq_o(rx_irq), .err_irq_o(err_irq));
    // ********************************************
    // shared tasks
    // ********************************************
    task automatic chk(input logic [31:0] g, e, input string m);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("mismatch at %0t: %s got %h", $time, m, g);
        end
    endtask : chk
    // classic cycle held until ack
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        dat <= d;
        @(posedge clk_i);
        while (ack !== 1'b1 && n < 50) begin
            n++;
            @(posedge clk_i);
        end
        if (n >= 50) chk(32'h0, 32'h1, "no ack");
        q = dat_o;
        cyc <= 0;
        stb <= 0;
        we <= 0;
    endtask : wb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask : wr
    // idle flag masked: it rises by itself
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input string m);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        if (a == ADR_STATUS_ONE) q[1] = 1'b0;
        chk(q, e, m);
    endtask : rd
    task automatic done(input string n);
        $display("test %s done", n);
    endtask : done
    // ********************************************
    // scenarios
    // ********************************************
    task automatic t_regs();
        rd(ADR_BAUD, 32'h0035, "baud reset");
        wr(ADR_CTRL_ONE, 32'hffff);
        rd(ADR_CTRL_ONE, 32'h3f7f, "ctrl mask");
        wr(ADR_CTRL_ONE, 32'h0);
        rd(8'h10, 32'h0, "unmapped");
        wr(ADR_BAUD, 32'h0); // fastest rt rate
        rd(ADR_BAUD, 32'h0, "baud write");
        done("regs");
    endtask : t_regs
    task automatic t_good();
        wr(ADR_CTRL_ONE, 32'h1501);
        tx.send(9'h0a5, 8, 1'b1);
        chk(32'(rx_irq), 32'h1, "rx irq");
        rd(ADR_STATUS_ONE, 32'h01, "good status");
        rd(ADR_DATA, 32'h1a5, "good data");
        chk(32'(rx_irq), 32'h0, "rx irq after clear");
        done("good");
    endtask : t_good
    task automatic t_fe();
        wr(ADR_CTRL_ONE, 32'h1001);
        tx.send(9'h03c, 8, 1'b0);
        chk(32'(rx_irq), 32'h0, "rx irq masked");
        chk(32'(err_irq), 32'h1, "fe irq");
        rd(ADR_STATUS_ONE, 32'h11, "fe status");
        rd(ADR_DATA, 32'h03c, "fe data");
        chk(32'(err_irq), 32'h0, "fe irq cleared");
        done("framing");
    endtask : t_fe
    task automatic t_break();
        wr(ADR_CTRL_ONE, 32'h0001);
        tx.send(9'h0, 8, 1'b0);
        rd(ADR_STATUS_ONE, 32'h51, "break status");
        rd(ADR_DATA, 32'h0, "break data");
        done("break");
    endtask : t_break
    task automatic t_over();
        wr(ADR_CTRL_ONE, 32'h0401);
        tx.send(9'h011, 8, 1'b1);
        tx.send(9'h022, 8, 1'b1); // back to back, first unread
        chk(32'(err_irq), 32'h1, "overrun irq");
        rd(ADR_STATUS_ONE, 32'h05, "overrun status");
        rd(ADR_DATA, 32'h011, "old data kept");
        done("overrun");
    endtask : t_over
    task automatic t_wake();
        wr(ADR_CTRL_ONE, 32'h0145);
        tx.send(9'h005, 8, 1'b1);
        rd(ADR_STATUS_ONE, 32'h0, "standby drop");
        chk(32'(rx_irq), 32'h0, "standby irq");
        tx.send(9'h085, 8, 1'b1);
        rd(ADR_STATUS_ONE, 32'h01, "address mark");
        rd(ADR_CTRL_ONE, 32'h0105, "standby cleared");
        chk(32'(rx_irq), 32'h1, "wake irq");
        wr(ADR_CTRL_ONE, 32'h0145); // foreign address: sleep again
        tx.send(9'h007, 8, 1'b1);
        rd(ADR_STATUS_ONE, 32'h01, "no overrun asleep");
        rd(ADR_DATA, 32'h185, "address data");
        done("wake");
    endtask : t_wake
    task automatic t_dbg();
        wr(ADR_CTRL_ONE, 32'h0001);
        tx.send(9'h033, 8, 1'b1);
        stop_m <= 1;
        repeat (40) @(posedge clk_i);
        stop_m <= 0;
        rd(ADR_STATUS_ONE, 32'h01, "stop keeps flags");
        dbg <= 1;
        rd(ADR_STATUS_ONE, 32'h01, "arm in break");
        rd(ADR_DATA, 32'h033, "data in break");
        rd(ADR_STATUS_ONE, 32'h01, "flags frozen");
        bce <= 1;
        rd(ADR_DATA, 32'h033, "data clear read");
        rd(ADR_STATUS_ONE, 32'h0, "arm with clear on");
        rd(ADR_DATA, 32'h033, "clear in break");
        rd(ADR_STATUS_ONE, 32'h0, "cleared in break");
        dbg <= 0;
        bce <= 0;
        rd(ADR_STATUS_ONE, 32'h0, "stays cleared");
        done("debug");
    endtask : t_dbg
    // ********************************************
    // verdict and run control
    // ********************************************
    task automatic final_report();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : final_report
    // watchdog, tests take under two thousand cycles
    initial begin
        repeat (30000) @(posedge clk_i);
        failures++;
        $display("mismatch at %0t: watchdog", $time);
        final_report();
    end
    // main sequence
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 0;
        t_regs();
        t_good();
        t_fe();
        t_break();
        t_over();
        t_wake();
        t_dbg();
        final_report();
    end
endmodule : asr_receiver_test
bind asr_receiver asr_receiver_monitor u_mon (.*);
`default_nettype wire
